// ### bench/ftc_prog_model.sv
// programming station model: pulses on the supply and the fuse bank
// assumes one ref_clk domain; fuses survive rst, like real blown links
module ftc_prog_model
    import ftc_pkg::*;
(
    input  wire logic        ref_clk,    // 10 MHz clock
    input  wire logic [23:0] fuse_blow,  // blow strobes from the block
    output ftc_pulse_s       pulse,      // pulse events toward the block
    output logic [23:0]      fuse_in     // fuse states read at power-on
);
    // ****************************************************************
    // fuse bank
    // ****************************************************************
    initial begin
        pulse   = '0;
        fuse_in = 24'h00_0000;
    end
    // blown fuses persist
    // no rst here: a supply cycle must not heal a blown link
    always @(posedge ref_clk) begin
        fuse_in <= fuse_in | fuse_blow;
    end
    // ****************************************************************
    // pulse tasks
    // ****************************************************************
    // one event per pulse
    // every event is followed by an idle cycle
    task automatic step(input logic m, input logic h, input logic b);
        @(posedge ref_clk);
        pulse <= '{mid_fall: m, high_pulse: h, high_blow: b};
        @(posedge ref_clk);
        pulse <= '0;
    endtask
    task automatic mids(input int n);
        repeat (n) step(1'b1, 1'b0, 1'b0);
    endtask
    task automatic seq(input int mode, input int key, input int code, input logic blow);
        mids(mode);
        step(1'b0, 1'b1, 1'b0);
        mids(key);
        step(1'b0, 1'b1, 1'b0);
        mids(code);
        if (blow) begin
            step(1'b0, 1'b1, 1'b1);
        end
        repeat (2) @(posedge ref_clk);
    endtask
endmodule

// ### bench/tb.sv
// self-checking bench for the code map loader and calibration window
// assumes ftc_prog_model as the station and a shortened window
module tb;
    import ftc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic        ref_clk = 1'b0;  // 100 ns period
    logic        rst     = 1'b1;  // power-on reset
    ftc_pulse_s  pulse;           // from the station
    logic [23:0] fuse_in;         // fuse bank states
    logic [23:0] fuse_blow;       // blow strobes
    ftc_trim_s   trim;            // effective trim codes
    logic        locked;          // lock fuse seen
    logic        cal_active;      // window running
    logic        field_select;    // output follows field
    int          failures    = 0; // mismatches
    int          checks_done = 0; // comparisons
    always #50 ref_clk = ~ref_clk;
    // short window: 2 periods of 16 cycles at frequency code 0
    ftc_loader #(.CAL_PERIODS_P(2), .BASE_CYC_P(16)) dut (
        .ref_clk(ref_clk), .rst(rst), .pulse(pulse), .fuse_in(fuse_in), .fuse_blow(fuse_blow),
        .trim(trim), .locked(locked), .cal_active(cal_active), .field_select(field_select));
    ftc_prog_model prog (.ref_clk(ref_clk), .fuse_blow(fuse_blow), .pulse(pulse), .fuse_in(fuse_in));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // supply cycle; a short hold is enough for an async reset
    task automatic power_cycle();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(2);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    // try mode: two registers held together, blow refused
    task automatic t_try();
        prog.seq(2, 2, 4, 1'b0);
        chk("duty", 24'h00_0004, trim.duty);
        prog.step(1'b0, 1'b1, 1'b0);
        prog.mids(1);
        prog.step(1'b0, 1'b1, 1'b0);
        prog.mids(3);
        prog.step(1'b0, 1'b1, 1'b1);
        cyc(2);
        chk("sens", 24'h00_0003, trim.sens);
        chk("duty kept", 24'h00_0004, trim.duty);
        chk("no blow in try", 24'h00_0000, fuse_in);
    endtask
    // saturation of duty and frequency, then supply cycle
    task automatic t_sat();
        prog.seq(2, 2, 600, 1'b0);
        chk("duty max", 24'h00_01FF, trim.duty);
        prog.seq(2, 3, 20, 1'b0);
        chk("freq max", 24'h00_000F, trim.freq);
        power_cycle();
        chk("trim cleared", 24'h00_0000, trim);
        chk("no window", 24'h00_0000, cal_active);
        chk("field out", 24'h00_0001, field_select);
    endtask
    // blow duty bit 2, survive a supply cycle
    task automatic t_blow();
        prog.seq(1, 2, 4, 1'b1);
        chk("duty fuse", 24'h00_0400, fuse_in);
        power_cycle();
        chk("duty kept", 24'h00_0004, trim.duty);
    endtask
    // blow the window fuse, then time the window
    task automatic t_cal();
        prog.seq(1, 5, 16, 1'b1);
        chk("cal fuse", 24'h20_0400, fuse_in);
        power_cycle();
        cyc(2);
        chk("window on", 24'h00_0001, cal_active);
        chk("quiescent", 24'h00_0000, field_select);
        cyc(24);
        chk("window held", 24'h00_0001, cal_active);
        cyc(12);
        chk("window over", 24'h00_0000, cal_active);
        chk("field back", 24'h00_0001, field_select);
    endtask
    // lock, then every programming attempt is ignored
    task automatic t_lock();
        prog.seq(1, 5, 512, 1'b1);
        chk("lock fuse", 24'h60_0400, fuse_in);
        power_cycle();
        chk("locked", 24'h00_0001, locked);
        prog.seq(2, 2, 5, 1'b0);
        chk("duty frozen", 24'h00_0004, trim.duty);
        prog.seq(1, 1, 1, 1'b1);
        chk("no blow", 24'h60_0400, fuse_in);
    endtask
    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(2);
        t_try();
        t_sat();
        t_blow();
        t_cal();
        t_lock();
        wrap_up();
    end
    initial begin
        #(20000 * 100);
        failures++;
        wrap_up();
    end
endmodule

// ### logic/ftc_loader.sv
// pulse code decoder, trim registers, fuse bank and calibration window
// assumes pulses are already qualified into one-cycle events and that
// rst is asserted at every power-on (supply cycle)
// limitation: a blow strobe carries every set bit of a sens, duty or freq code, and bits 4 and 9 of a special code;
// the station must address one bit per supply cycle because fuse current
// only allows one link at a time, and the block does not police that
// ****************************************************************
// Behaviour
// - mode code 1 selects blow mode
// - mode code 2 selects volatile try mode
// - sensitivity key 1, code 0 to 255
// - duty key 2, codes 0 to 255 raise
// - duty bit 256 reverses trim direction
// - duty code 511 gives minimum duty
// - frequency key 3, codes 0 to 15
// - special key 5, code 16 calibration fuse
// - special code 512 is lock fuse
// - lock fuse blown only in mode 1
// - mid pulse falling edge increments code
// - power cycle clears unblown bits only
// - window outputs programmed quiescent duty
// - window holds 50 ms after power-up
// - window scales inversely with carrier frequency
// - window only when its fuse blown
// - locked device ignores all programming
// ****************************************************************
module ftc_loader
    import ftc_pkg::*;
#(
    parameter int unsigned CAL_PERIODS_P = CAL_PERIODS,      // carrier periods per window
    parameter int unsigned BASE_CYC_P    = CARRIER_BASE_CYC  // cycles per target period
) (
    input  wire logic        ref_clk,        // 10 MHz clock
    input  wire logic        rst,            // asynchronous reset, power-on
    input  wire ftc_pulse_s  pulse,          // detected supply pulse events
    input  wire logic [23:0] fuse_in,        // fuse states read at power-on
    output logic [23:0]      fuse_blow,      // one-cycle blow strobe per fuse bit
    output ftc_trim_s        trim,           // effective trim codes
    output logic             locked,         // lock fuse blown
    output logic             cal_active,     // calibration window running
    output logic             field_select    // high: output follows field
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // refuse sizes that the counters cannot hold: cal_per is 16 bits,
    // and the slowest carrier period, under twice the base, must fit 22 bits
    if (CAL_PERIODS_P < 1 || CAL_PERIODS_P > 65535) begin : g_bad_periods
        $error("ftc_loader: window period count out of range");
    end
    if (BASE_CYC_P < 16 || BASE_CYC_P > 2097151) begin : g_bad_base
        $error("ftc_loader: carrier base period out of range");
    end

    // fuse word layout: [7:0] sens, [16:8] duty, [20:17] freq, [21] cal, [22] lock
    localparam int unsigned FB_CAL  = 21;
    localparam int unsigned FB_LOCK = 22;

    // ****************************************************************
    // state
    // ****************************************************************
    ftc_state_e       state;           // programming step
    logic [1:0]       mode;            // mid pulses counted in mode step
    logic [2:0]       key;             // mid pulses counted in key step
    logic [9:0]       code;            // address code of current field
    logic [23:0]      fuse;            // fuse image captured after reset
    logic             fuse_loaded;     // image valid
    logic [7:0]       try_sens;        // volatile sensitivity code
    logic [8:0]       try_duty;        // volatile duty code
    logic [3:0]       try_freq;        // volatile frequency code
    logic [21:0]      cal_cnt;         // cycles elapsed in the current carrier period
    logic [15:0]      cal_per;         // carrier periods counted
    logic             cal_done;        // window over

    // ****************************************************************
    // decode
    // ****************************************************************
    wire        in_blow   = (mode == MODE_BLOW);                   // blow mode
    wire        in_try    = (mode == MODE_TRY);                    // try mode
    wire        prog_ok   = fuse_loaded && !fuse[FB_LOCK];
    wire [9:0]  field_max = (key == KEY_SENS)    ? MAX_SENS :
                            (key == KEY_DUTY)    ? MAX_DUTY :
                            (key == KEY_FREQ)    ? MAX_FREQ :
                            (key == KEY_SPECIAL) ? MAX_SPECIAL : CODE_RESET;
    wire        code_inc  = prog_ok && pulse.mid_fall && state == FTC_FIELD && code < field_max;
    wire        blow_ev   = prog_ok && pulse.high_blow && state == FTC_FIELD && in_blow;
    // sens, duty, freq or special addressed as fuse word bits
    wire [23:0] field_bits = (key == KEY_SENS)    ? {16'h0000, code[7:0]} :
                             (key == KEY_DUTY)    ? {7'h00, code[8:0], 8'h00} :
                             (key == KEY_FREQ)    ? {3'h0, code[3:0], 17'h0_0000} :
                             (key == KEY_SPECIAL) ? {1'b0, code[9], code[4], 21'h00_0000} : 24'h00_0000;

    // ****************************************************************
    // programming step machine
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= FTC_MODE;
            mode  <= 2'h0;
            key   <= 3'h0;
            code  <= CODE_RESET;
        end else if (prog_ok) begin
            if (pulse.high_pulse && !pulse.high_blow) begin
                unique case (state)
                    FTC_MODE:  state <= FTC_KEY;
                    FTC_KEY:   state <= FTC_FIELD;
                    // try mode loops back to key selection, code restarts
                    FTC_FIELD: begin
                        state <= in_try ? FTC_KEY : FTC_FIELD;
                        key   <= in_try ? 3'h0 : key;
                        code  <= in_try ? CODE_RESET : code;
                    end
                endcase
            end else if (pulse.mid_fall) begin
                unique case (state)
                    FTC_MODE:  mode <= (mode == 2'h3) ? mode : mode + 2'h1;
                    FTC_KEY:   key  <= (key == 3'h7) ? key : key + 3'h1;
                    FTC_FIELD: code <= code_inc ? code + 10'h001 : code;
                endcase
            end
        end
    end

    // ****************************************************************
    // volatile trim registers, cleared at power-on
    // ****************************************************************
    // unblown bits reset by supply cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            try_sens <= 8'h00;
            try_duty <= 9'h000;
            try_freq <= 4'h0;
        end else if (state == FTC_FIELD && prog_ok && (in_try || in_blow)) begin
            // sens, duty, freq follow the addressed code
            if (key == KEY_SENS) begin
                try_sens <= code[7:0];
            end
            if (key == KEY_DUTY) begin
                try_duty <= code[8:0];
            end
            if (key == KEY_FREQ) begin
                try_freq <= code[3:0];
            end
        end
    end

    // ****************************************************************
    // fuse image, captured after reset release
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fuse        <= 24'h00_0000;
            fuse_loaded <= 1'b0;
            fuse_blow   <= 24'h00_0000;
        end else begin
            fuse_loaded <= 1'b1;
            fuse_blow   <= 24'h00_0000;
            if (!fuse_loaded) begin
                fuse <= fuse_in;
            end else if (blow_ev) begin
                // lock fuse only in blow mode; lock bit at 512
                fuse_blow <= field_bits;
                fuse      <= fuse | field_bits;
            end
        end
    end

    // bit 8 reverses, 511 is minimum: the analogue side reads bit 8 as direction
    assign trim.sens = fuse[7:0]   | try_sens;
    assign trim.duty = fuse[16:8]  | try_duty;
    assign trim.freq = fuse[20:17] | try_freq;
    assign locked    = fuse[FB_LOCK];

    // ****************************************************************
    // calibration window
    // ****************************************************************
    // carrier period grows with frequency code (lower frequency)
    wire [21:0] period_cyc = 22'(BASE_CYC_P + (BASE_CYC_P / 16) * trim.freq);

    // count carrier periods from power-up; only with fuse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cal_cnt  <= 22'h00_0000;
            cal_per  <= 16'h0000;
            cal_done <= 1'b0;
        end else if (fuse_loaded && !cal_done) begin
            if (!fuse[FB_CAL]) begin
                cal_done <= 1'b1;
            end else if (cal_cnt + 22'h00_0001 >= period_cyc) begin
                cal_cnt  <= 22'h00_0000;
                cal_per  <= cal_per + 16'h0001;
                cal_done <= (32'(cal_per) + 1 >= CAL_PERIODS_P);
            end else begin
                cal_cnt <= cal_cnt + 22'h00_0001;
            end
        end
    end

    // fuse at code 16 enables window; quiescent duty forced
    assign cal_active   = fuse_loaded && fuse[FB_CAL] && !cal_done;
    assign field_select = cal_done;

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_locked;
        fuse_loaded && fuse[FB_LOCK];
    endsequence

    AST_LOCK_NO_BLOW: assert property (@(posedge ref_clk) disable iff (rst)
        s_locked |=> fuse_blow == 24'h00_0000) else $error("blow while locked");
    AST_LOCK_MODE: assert property (@(posedge ref_clk) disable iff (rst)
        fuse_blow[FB_LOCK] |-> $past(mode) == MODE_BLOW) else $error("lock outside blow mode");
    AST_SATURATE: assert property (@(posedge ref_clk) disable iff (rst)
        state == FTC_FIELD && code == field_max && !pulse.high_pulse |=> $stable(code))
        else $error("code passed maximum");
    AST_INC: assert property (@(posedge ref_clk) disable iff (rst)
        code_inc && !pulse.high_pulse |=> code == $past(code) + 10'h001) else $error("no increment");
    AST_NO_CAL: assert property (@(posedge ref_clk) disable iff (rst)
        fuse_loaded && !fuse[FB_CAL] |-> !cal_active) else $error("window without fuse");
    AST_CAL_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        cal_active |-> !field_select) else $error("field output during window");
    AST_TRY_VOLATILE: assert property (@(posedge ref_clk) disable iff (rst)
        in_try |=> fuse_blow == 24'h00_0000) else $error("blow in try mode");
    AST_FREQ_MAX: assert property (@(posedge ref_clk) disable iff (rst)
        key == KEY_FREQ |-> code <= MAX_FREQ) else $error("frequency code over 15");

    // ****************************************************************
    // further checks: fuse image, programming steps and window
    // ****************************************************************
    // a try-mode step from field back to key selection
    sequence s_try_step;
        prog_ok && state == FTC_FIELD && in_try && pulse.high_pulse && !pulse.high_blow;
    endsequence

    // the first cycle of a calibration window
    sequence s_window_start;
        $rose(cal_active);
    endsequence

    // the window lasts at least one carrier period of 16 or more cycles, so eight cycles is a safe floor
    sequence s_window_body;
        cal_active [*8];
    endsequence

    AST_FUSE_CAPTURE: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(fuse_loaded) |-> fuse == $past(fuse_in)) else $error("fuse image not captured");

    AST_FUSE_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
        fuse_loaded && $past(fuse_loaded) |-> (fuse & $past(fuse)) == $past(fuse))
        else $error("blown fuse cleared");

    // a strobe lands in the image at once
    AST_BLOW_IMAGE: assert property (@(posedge ref_clk) disable iff (rst)
        fuse_blow != 24'h00_0000 |-> (fuse & fuse_blow) == fuse_blow) else $error("blown bit missing from image");

    // blow only from field addressing in blow mode
    AST_BLOW_FIELD: assert property (@(posedge ref_clk) disable iff (rst)
        fuse_blow != 24'h00_0000 |-> $past(state) == FTC_FIELD && $past(mode) == MODE_BLOW)
        else $error("blow outside field step");

    // mode count frozen after mode step
    AST_MODE_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        state != FTC_MODE |-> $stable(mode)) else $error("mode changed after selection");

    // blow mode addresses a single parameter
    AST_KEY_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        state == FTC_FIELD && !in_try |-> $stable(key)) else $error("key changed in blow mode");

    // try mode loops back with a fresh code
    AST_TRY_LOOP: assert property (@(posedge ref_clk) disable iff (rst)
        s_try_step |=> state == FTC_KEY && code == CODE_RESET && key == 3'h0)
        else $error("try mode did not loop to key selection");

    AST_SENS_FOLLOW: assert property (@(posedge ref_clk) disable iff (rst)
        prog_ok && state == FTC_FIELD && (in_try || in_blow) && key == KEY_SENS |=> try_sens == $past(code[7:0]))
        else $error("sensitivity code not applied");

    AST_DUTY_FOLLOW: assert property (@(posedge ref_clk) disable iff (rst)
        prog_ok && state == FTC_FIELD && (in_try || in_blow) && key == KEY_DUTY |=> try_duty == $past(code[8:0]))
        else $error("duty code not applied");

    // calibration fuse only from a special code with bit 4 (16) set
    AST_CAL_MAP: assert property (@(posedge ref_clk) disable iff (rst)
        fuse_blow[FB_CAL] |-> $past(key) == KEY_SPECIAL && $past(code[4])) else $error("calibration fuse misaddressed");

    // lock fuse only from special code 512
    AST_LOCK_MAP: assert property (@(posedge ref_clk) disable iff (rst)
        fuse_blow[FB_LOCK] |-> $past(key) == KEY_SPECIAL && $past(code) == SPECIAL_LOCK_BIT)
        else $error("lock fuse misaddressed");

    // a locked device keeps every step and code
    AST_LOCK_FREEZE: assert property (@(posedge ref_clk) disable iff (rst)
        s_locked |=> $stable(state) && $stable(mode) && $stable(key) && $stable(code) && $stable(try_duty))
        else $error("programming moved while locked");

    // the window runs for a stretch, not a glitch
    AST_CAL_SPAN: assert property (@(posedge ref_clk) disable iff (rst)
        s_window_start |-> s_window_body) else $error("window shorter than eight cycles");

    // the window ends for good until the next power-on
    AST_CAL_ONCE: assert property (@(posedge ref_clk) disable iff (rst)
        cal_done |=> !cal_active && field_select) else $error("window reopened before power-on");

endmodule

// ### logic/ftc_pkg.sv
// package for the fuse trim code map and calibration window block
// assumes one 10 MHz clock and pulse events already detected upstream
package ftc_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ            = 10_000_000;  // ref_clk rate
    localparam int unsigned CAL_WINDOW_MS     = 50;          // window at target carrier
    localparam int unsigned CAL_TARGET_HZ     = 2_000;       // target carrier frequency
    // carrier periods in the window at target rate (50 ms * 2 kHz)
    localparam int unsigned CAL_PERIODS       = CAL_WINDOW_MS * CAL_TARGET_HZ / 1000;
    // clock cycles in one target carrier period (whole cycles, at least one)
    localparam int unsigned CARRIER_BASE_CYC  = CLK_HZ / CAL_TARGET_HZ;

    // ****************************************************************
    // programming codes
    // ****************************************************************
    localparam logic [1:0] MODE_BLOW          = 2'h1;        // blow and lock mode
    localparam logic [1:0] MODE_TRY           = 2'h2;        // try mode
    localparam logic [2:0] KEY_SENS           = 3'h1;        // sensitivity trim
    localparam logic [2:0] KEY_DUTY           = 3'h2;        // quiescent duty trim
    localparam logic [2:0] KEY_FREQ           = 3'h3;        // carrier frequency
    localparam logic [2:0] KEY_SPECIAL        = 3'h5;        // calibration and lock fuses
    localparam int unsigned FIELD_W           = 10;          // widest bit field code
    localparam logic [9:0] MAX_SENS           = 10'h0FF;     // 255
    localparam logic [9:0] MAX_DUTY           = 10'h1FF;     // 511
    localparam logic [9:0] MAX_FREQ           = 10'h00F;     // 15
    localparam logic [9:0] MAX_SPECIAL        = 10'h200;     // 512
    localparam logic [9:0] DUTY_REVERSE       = 10'h100;     // 256, direction bit
    localparam logic [9:0] SPECIAL_CAL_BIT    = 10'h010;     // 16, calibration enable fuse
    localparam logic [9:0] SPECIAL_LOCK_BIT   = 10'h200;     // 512, lock fuse
    localparam logic [9:0] CODE_RESET         = 10'h000;     // initial code of every field

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {FTC_MODE, FTC_KEY, FTC_FIELD} ftc_state_e;

    // effective trim values toward the analogue side
    typedef struct packed {
        logic [7:0] sens;       // sensitivity code
        logic [8:0] duty;       // duty code, bit 8 reverses direction
        logic [3:0] freq;       // carrier frequency code
    } ftc_trim_s;

    // pulse events from the supply level detector
    typedef struct packed {
        logic mid_fall;         // falling edge of a mid_level_pulse
        logic high_pulse;       // a high_level_pulse, step event
        logic high_blow;        // a high_level_pulse long enough to blow
    } ftc_pulse_s;

endpackage
